/* common/pieb_defs.svh */
// Constants of the peripheral interrupt enable bank.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PIEB_DEFS_SVH
`define PIEB_DEFS_SVH

// Register map, one aligned word per register
`define PIEB_NUM_REGS 6
`define PIEB_IDX_W 3
`define PIEB_OFS_EN1 32'h00000000
`define PIEB_OFS_EN2 32'h00000004
`define PIEB_OFS_EN3 32'h00000008
`define PIEB_OFS_EN4 32'h0000000C
`define PIEB_OFS_EN5 32'h00000010
`define PIEB_OFS_EN6 32'h00000014

// Reset value of every enable register
`define PIEB_RESET_VAL 8'h00

// Writable bits per register, full-size variant
`define PIEB_WMASK1 8'h7F
`define PIEB_WMASK2 8'hBF
`define PIEB_WMASK3 8'hCF
`define PIEB_WMASK4 8'hFF
`define PIEB_WMASK5 8'hFF
`define PIEB_WMASK6 8'h17

// Bits absent on the small program memory variant
`define PIEB_SMALL_GONE4 8'hC0
`define PIEB_SMALL_GONE5 8'hE8

// Read-only zero bits of the third register
`define PIEB_RO3 8'h30

// Field positions
`define PIEB_BIT_DISPLAY 6
`define PIEB_REQ_DISPLAY 22

// Bus answers
`define PIEB_RESP_OKAY 2'h0
`define PIEB_RESP_SLVERR 2'h2

`endif

/* common/pieb_pkg.sv */
// Types of the peripheral interrupt enable bank.
// Assumes pieb_defs.svh for all numeric constants.
package pieb_pkg;

    typedef enum {
        WR_IDLE,
        WR_RESP
    } pieb_wr_state_t;

    typedef logic [7:0] pieb_byte_t;

endpackage

/* verilog/pieb_req_mask.sv */
// Flag-and-enable masking with one combined request toward the core.
// Assumes flags and enables come from logic on the same clock.
`timescale 1ns/1ps
`include "pieb_defs.svh"

module pieb_req_mask
    import pieb_pkg::*;
#(
    parameter int WIDTH = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sources
    input wire logic [WIDTH-1:0] flags,
    input wire logic [WIDTH-1:0] enables,
    input wire logic gateOpen,
    // Toward the core
    output logic [WIDTH-1:0] maskedReq_ff,
    output logic anyReq_ff
);

    logic [WIDTH-1:0] nxt_maskedReq;
    logic nxt_anyReq;

    ////////////////////////////////////////////////////////////////////
    // One AND gate per source
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_mask
            assign nxt_maskedReq[gi] = flags[gi] & enables[gi]; // R13
        end
    endgenerate

    always_comb begin
        nxt_anyReq = (|nxt_maskedReq) & gateOpen; // R13 R12
    end

    ////////////////////////////////////////////////////////////////////
    // Registered so the core sees glitch-free levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            maskedReq_ff <= '0;
            anyReq_ff <= 1'b0;
        end else begin
            maskedReq_ff <= nxt_maskedReq;
            anyReq_ff <= nxt_anyReq;
        end
    end

endmodule // pieb_req_mask

/* verilog/pieb_axil_slave.sv */
// AXI4-Lite slave front end for the enable bank.
// Assumes the bank returns read data combinationally for rdIdx.
`timescale 1ns/1ps
`include "pieb_defs.svh"

module pieb_axil_slave
    import pieb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Write address and data
    input wire logic [31:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // Write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // Read
    input wire logic [31:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Register side
    output logic wrEn,
    output logic [`PIEB_IDX_W-1:0] wrIdx,
    output pieb_byte_t wrByte,
    output logic [`PIEB_IDX_W-1:0] rdIdx,
    input wire pieb_byte_t rdByte
);

    pieb_wr_state_t wrState_ff, nxt_wrState;
    logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
    logic [31:0] awAddr_ff, nxt_awAddr;
    pieb_byte_t wData_ff, nxt_wData;
    logic wStrb0_ff, nxt_wStrb0;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wrHit, rdHit, bothHeld;

    function automatic logic [`PIEB_IDX_W:0] decode(input logic [31:0] a);
        case (a)
            `PIEB_OFS_EN1: decode = 4'h8;
            `PIEB_OFS_EN2: decode = 4'h9;
            `PIEB_OFS_EN3: decode = 4'hA;
            `PIEB_OFS_EN4: decode = 4'hB;
            `PIEB_OFS_EN5: decode = 4'hC;
            `PIEB_OFS_EN6: decode = 4'hD;
            default: decode = 4'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Write path: address and data taken in either order
    always_comb begin
        {wrHit, wrIdx} = decode(awAddr_ff);
        {rdHit, rdIdx} = decode(s_axil_araddr);
        bothHeld = awHeld_ff & wHeld_ff;
        s_axil_awready = (wrState_ff == WR_IDLE) & ~awHeld_ff;
        s_axil_wready = (wrState_ff == WR_IDLE) & ~wHeld_ff;
        s_axil_bvalid = (wrState_ff == WR_RESP);
        wrEn = (wrState_ff == WR_IDLE) & bothHeld & wrHit & wStrb0_ff;
        wrByte = wData_ff;
        nxt_wrState = wrState_ff;
        nxt_awHeld = awHeld_ff;
        nxt_wHeld = wHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wData = wData_ff;
        nxt_wStrb0 = wStrb0_ff;
        nxt_bresp = bresp_ff;
        case (wrState_ff)
            WR_IDLE: begin
                if (s_axil_awvalid && s_axil_awready) begin
                    nxt_awHeld = 1'b1;
                    nxt_awAddr = s_axil_awaddr;
                end
                if (s_axil_wvalid && s_axil_wready) begin
                    nxt_wHeld = 1'b1;
                    nxt_wData = s_axil_wdata[7:0];
                    nxt_wStrb0 = s_axil_wstrb[0];
                end
                if (bothHeld) begin
                    nxt_wrState = WR_RESP;
                    nxt_awHeld = 1'b0;
                    nxt_wHeld = 1'b0;
                    nxt_bresp = wrHit ? `PIEB_RESP_OKAY : `PIEB_RESP_SLVERR;
                end
            end
            WR_RESP: begin
                if (s_axil_bready) begin
                    nxt_wrState = WR_IDLE;
                end
            end
            default: nxt_wrState = WR_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read path: one outstanding read, answer one cycle after taking
    always_comb begin
        s_axil_arready = ~rvalid_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axil_arvalid && s_axil_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rdHit ? {24'h000000, rdByte} : 32'h00000000;
            nxt_rresp = rdHit ? `PIEB_RESP_OKAY : `PIEB_RESP_SLVERR;
        end else if (rvalid_ff && s_axil_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrState_ff <= WR_IDLE;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 32'h00000000;
            wData_ff <= 8'h00;
            wStrb0_ff <= 1'b0;
            bresp_ff <= `PIEB_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PIEB_RESP_OKAY;
        end else begin
            wrState_ff <= nxt_wrState;
            awHeld_ff <= nxt_awHeld;
            wHeld_ff <= nxt_wHeld;
            awAddr_ff <= nxt_awAddr;
            wData_ff <= nxt_wData;
            wStrb0_ff <= nxt_wStrb0;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axil_bresp = bresp_ff;
    assign s_axil_rvalid = rvalid_ff;
    assign s_axil_rdata = rdata_ff;
    assign s_axil_rresp = rresp_ff;

endmodule // pieb_axil_slave

/* verilog/pieb_enable_bank.sv */
// Six peripheral interrupt enable registers with request masking.
// Assumes flags, gate bits and display mode come from same-clock logic.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pieb_defs.svh"

// Function
// R1: All enable bits clear at power-on reset
// R2: First register: converter, serial1, sync1, timers 1/2
// R3: Second register: oscillator, sync2, collisions, voltage, timer3
// R4: Third register: timer5 gate, display, serial2, capcomp
// R5: Third register serial2 bits read-only zero
// R6: Display enable effective only in Type-B non-static
// R7: Fourth register: capture/compare ten down to three
// R8: Small variant lacks capcomp ten and nine
// R9: Fifth register: timers 4 through 12 events
// R10: Small variant lacks four fifth-register bits
// R11: Sixth register: nonvolatile write, comparators three-one
// R12: Without priority scheme, gate enable also required
// R13: Masked requests ANDed, then ORed to core
module pieb_enable_bank
    import pieb_pkg::*;
#(
    parameter bit SMALL_PROG_MEM = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write
    input wire logic [31:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Peripheral flags, one byte per flag register
    input wire logic [7:0] flags1,
    input wire logic [7:0] flags2,
    input wire logic [7:0] flags3,
    input wire logic [7:0] flags4,
    input wire logic [7:0] flags5,
    input wire logic [7:0] flags6,
    // Core gating and display mode
    input wire logic priorityEn,
    input wire logic peripheralGateEn,
    input wire logic displayTypeBNonStatic,
    // Toward the core
    output logic [47:0] maskedReq,
    output logic periphIrq,
    output logic [7:0] enable1,
    output logic [7:0] enable2,
    output logic [7:0] enable3,
    output logic [7:0] enable4,
    output logic [7:0] enable5,
    output logic [7:0] enable6
);

    localparam int NREG = `PIEB_NUM_REGS;

    // Variant masks; absent bits are never writable
    localparam pieb_byte_t GONE4 = SMALL_PROG_MEM ? `PIEB_SMALL_GONE4 : 8'h00;
    localparam pieb_byte_t GONE5 = SMALL_PROG_MEM ? `PIEB_SMALL_GONE5 : 8'h00;

    pieb_byte_t wmask [NREG];
    pieb_byte_t en_ff [NREG];
    pieb_byte_t nxt_en [NREG];
    logic wrEn;
    logic [`PIEB_IDX_W-1:0] wrIdx;
    logic [`PIEB_IDX_W-1:0] rdIdx;
    pieb_byte_t wrByte;
    pieb_byte_t rdByte;
    pieb_byte_t en3Eff;
    logic [47:0] flagAll;
    logic [47:0] enAll;
    logic gateOpen;

    ////////////////////////////////////////////////////////////////////
    // Bus front end
    pieb_axil_slave u_slave (
        .clk(clk),
        .rst_b(rst_b),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wrEn(wrEn),
        .wrIdx(wrIdx),
        .wrByte(wrByte),
        .rdIdx(rdIdx),
        .rdByte(rdByte)
    );

    ////////////////////////////////////////////////////////////////////
    // Writable bits per register
    always_comb begin
        wmask[0] = `PIEB_WMASK1; // R2
        wmask[1] = `PIEB_WMASK2; // R3
        wmask[2] = `PIEB_WMASK3 & ~`PIEB_RO3; // R4 R5
        wmask[3] = `PIEB_WMASK4 & ~GONE4; // R7 R8
        wmask[4] = `PIEB_WMASK5 & ~GONE5; // R9 R10
        wmask[5] = `PIEB_WMASK6; // R11
    end

    ////////////////////////////////////////////////////////////////////
    // Enable storage; unimplemented bits stay zero because never written
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            nxt_en[i] = en_ff[i];
            if (wrEn && (wrIdx == i[`PIEB_IDX_W-1:0])) begin
                nxt_en[i] = wrByte & wmask[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NREG; i++) begin
                en_ff[i] <= `PIEB_RESET_VAL; // R1
            end
        end else begin
            for (int i = 0; i < NREG; i++) begin
                en_ff[i] <= nxt_en[i];
            end
        end
    end

    // Read mux; indices past the map read zero
    always_comb begin
        rdByte = 8'h00;
        if (rdIdx < NREG[`PIEB_IDX_W-1:0]) begin
            rdByte = en_ff[rdIdx];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Masking toward the core
    always_comb begin
        en3Eff = en_ff[2];
        // Display request only meaningful in Type-B non-static drive
        en3Eff[`PIEB_BIT_DISPLAY] = en_ff[2][`PIEB_BIT_DISPLAY] & displayTypeBNonStatic; // R6
        enAll = {en_ff[5], en_ff[4], en_ff[3], en3Eff, en_ff[1], en_ff[0]};
        flagAll = {flags6, flags5, flags4, flags3, flags2, flags1};
        gateOpen = priorityEn | peripheralGateEn; // R12
    end

    pieb_req_mask #(
        .WIDTH(48)
    ) u_mask (
        .clk(clk),
        .rst_b(rst_b),
        .flags(flagAll),
        .enables(enAll),
        .gateOpen(gateOpen),
        .maskedReq_ff(maskedReq),
        .anyReq_ff(periphIrq)
    );

    assign enable1 = en_ff[0];
    assign enable2 = en_ff[1];
    assign enable3 = en_ff[2];
    assign enable4 = en_ff[3];
    assign enable5 = en_ff[4];
    assign enable6 = en_ff[5];

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Helper: no register write seen since reset
    logic seenWr_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seenWr_ff <= 1'b0;
        end else if (wrEn) begin
            seenWr_ff <= 1'b1;
        end
    end

    sequence s_wr(int idx);
        wrEn && (wrIdx == idx);
    endsequence

    sequence s_dispBlocked;
        flags3[`PIEB_BIT_DISPLAY] && !displayTypeBNonStatic;
    endsequence

    property p_rst_clear;
        !seenWr_ff |-> (enAll == 48'h0);
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("enable set without write"); // R1

    property p_wr1;
        s_wr(0) |=> (enable1 == ($past(wrByte) & 8'h7F)) && !enable1[7];
    endproperty
    a_wr1: assert property (p_wr1) else $error("first register write wrong"); // R2

    property p_wr2;
        s_wr(1) |=> (enable2 == ($past(wrByte) & 8'hBF)) && !enable2[6];
    endproperty
    a_wr2: assert property (p_wr2) else $error("second register write wrong"); // R3

    property p_wr3;
        s_wr(2) |=> (enable3 == ($past(wrByte) & 8'hCF));
    endproperty
    a_wr3: assert property (p_wr3) else $error("third register write wrong"); // R4

    property p_ro3;
        (enable3[5:4] == 2'h0) and (s_wr(2) |=> $stable(enable3[5:4]));
    endproperty
    a_ro3: assert property (p_ro3) else $error("read-only serial2 bits changed"); // R5

    property p_disp;
        s_dispBlocked ##0 enable3[`PIEB_BIT_DISPLAY] |=> !maskedReq[`PIEB_REQ_DISPLAY];
    endproperty
    a_disp: assert property (p_disp) else $error("display request leaked"); // R6

    property p_wr4;
        s_wr(3) |=> (enable4 == ($past(wrByte) & ~GONE4));
    endproperty
    a_wr4: assert property (p_wr4) else $error("fourth register write wrong"); // R7

    property p_small4;
        SMALL_PROG_MEM |-> (enable4[7:6] == 2'h0);
    endproperty
    a_small4: assert property (p_small4) else $error("absent capcomp bits set"); // R8

    property p_wr5;
        s_wr(4) |=> (enable5 == ($past(wrByte) & ~GONE5));
    endproperty
    a_wr5: assert property (p_wr5) else $error("fifth register write wrong"); // R9

    property p_small5;
        SMALL_PROG_MEM |-> ((enable5 & 8'hE8) == 8'h00);
    endproperty
    a_small5: assert property (p_small5) else $error("absent timer bits set"); // R10

    property p_wr6;
        ((enable6 & 8'hE8) == 8'h00) and (s_wr(5) |=> enable6 == ($past(wrByte) & 8'h17));
    endproperty
    a_wr6: assert property (p_wr6) else $error("sixth register wrong"); // R11

    property p_gate;
        (!priorityEn && !peripheralGateEn) |=> !periphIrq;
    endproperty
    a_gate: assert property (p_gate) else $error("request passed closed gate"); // R12

    property p_any;
        ((|(flagAll & enAll)) && gateOpen) |=> periphIrq ##0 (maskedReq != 48'h0);
    endproperty
    a_any: assert property (p_any) else $error("masked request not raised"); // R13

    property p_none;
        !(|(flagAll & enAll)) |=> !periphIrq && (maskedReq == 48'h0);
    endproperty
    a_none: assert property (p_none) else $error("request without enabled flag"); // R13

endmodule // pieb_enable_bank

/* bench/pieb_flag_model.sv */
// Model of the peripheral flag sources and of the core's gate bits.
// Assumes commands from the bench change just after a rising edge.
`timescale 1ns/1ps

module pieb_flag_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bench commands
    input wire logic [47:0] flagsCmd,
    input wire logic [2:0] gateCmd,
    // Toward the bank
    output logic [7:0] flags1,
    output logic [7:0] flags2,
    output logic [7:0] flags3,
    output logic [7:0] flags4,
    output logic [7:0] flags5,
    output logic [7:0] flags6,
    output logic priorityEn,
    output logic peripheralGateEn,
    output logic displayTypeBNonStatic
);
    logic [47:0] flags_ff;
    logic [2:0] gate_ff;

    ////////////////////////////////////////////////////////////////////////
    // Flags held as levels, as peripherals keep them until software clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= 48'h000000000000;
            gate_ff <= 3'h0;
        end else begin
            flags_ff <= flagsCmd;
            gate_ff <= gateCmd;
        end
    end

    assign {flags6, flags5, flags4, flags3, flags2, flags1} = flags_ff;
    assign {displayTypeBNonStatic, priorityEn, peripheralGateEn} = gate_ff;
endmodule // pieb_flag_model

/* bench/pieb_enable_bank_tb.sv */
// Self-checking bench for the enable bank over AXI4-Lite.
// Assumes the flag model adds one register stage before the bank.
`timescale 1ns/1ps

module pieb_enable_bank_tb
    import pieb_pkg::*;
#(
    parameter bit SMALL = 1'b0
);
    // Writable bits, register six down to one
    localparam logic [47:0] WMASK = {8'h17, SMALL ? 8'h17 : 8'hFF, SMALL ? 8'h3F : 8'hFF,
        8'hCF, 8'hBF, 8'h7F};
    localparam logic [47:0] DISP = 48'h000000400000;
    logic clk = 1'b0, rst_b = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, periphIrq, prio, gate, disp;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] f1, f2, f3, f4, f5, f6, e1, e2, e3, e4, e5, e6, small4, small5;
    logic [47:0] maskedReq, flagsCmd = 48'h0, expM;
    logic [2:0] gateCmd = 3'h0;
    logic [31:0] rd;
    int fail_count = 0, compares = 0;

    ////////////////////////////////////////////////////////////////////////
    pieb_enable_bank #(.SMALL_PROG_MEM(SMALL)) u_dut (.clk(clk), .rst_b(rst_b),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready), .flags1(f1), .flags2(f2),
        .flags3(f3), .flags4(f4), .flags5(f5), .flags6(f6), .priorityEn(prio),
        .peripheralGateEn(gate), .displayTypeBNonStatic(disp), .maskedReq(maskedReq),
        .periphIrq(periphIrq), .enable1(e1), .enable2(e2), .enable3(e3), .enable4(e4),
        .enable5(e5), .enable6(e6));

    // Small program memory variant in lockstep on the same bus and flags
    pieb_enable_bank #(.SMALL_PROG_MEM(1'b1)) u_small (.clk(clk), .rst_b(rst_b),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(), .s_axil_bresp(), .s_axil_bvalid(), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(),
        .s_axil_rdata(), .s_axil_rresp(), .s_axil_rvalid(), .s_axil_rready(rready),
        .flags1(f1), .flags2(f2), .flags3(f3), .flags4(f4), .flags5(f5), .flags6(f6),
        .priorityEn(prio), .peripheralGateEn(gate), .displayTypeBNonStatic(disp),
        .maskedReq(), .periphIrq(), .enable1(), .enable2(), .enable3(),
        .enable4(small4), .enable5(small5), .enable6());

    pieb_flag_model u_model (.clk(clk), .rst_b(rst_b), .flagsCmd(flagsCmd),
        .gateCmd(gateCmd), .flags1(f1), .flags2(f2), .flags3(f3), .flags4(f4),
        .flags5(f5), .flags6(f6), .priorityEn(prio), .peripheralGateEn(gate),
        .displayTypeBNonStatic(disp));

    initial begin
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshake decisions use values settled before the next rising edge
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, aok, wok;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(negedge clk);
            aok = aw && awready;
            wok = w && wready;
            @(posedge clk);
            if (aok) awvalid <= 1'b0;
            if (aok) aw = 1'b0;
            if (wok) wvalid <= 1'b0;
            if (wok) w = 1'b0;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic drive(input logic [47:0] f, input logic [2:0] g);
        @(posedge clk);
        flagsCmd <= f;
        gateCmd <= g;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            axr(i * 4);
            chk({16'h0, rd}, 48'h0);
        end
        // All ones into each register, only implemented bits stick
        for (int i = 0; i < 6; i++) begin
            axw(i * 4, 32'hFFFFFFFF, 4'hF);
            chk({46'h0, resp}, 48'h0);
            axr(i * 4);
            chk({16'h0, rd}, {40'h0, WMASK[i*8+:8]});
        end
        chk({e6, e5, e4, e3, e2, e1}, WMASK);
        chk({32'h0, small5, small4}, {32'h0, 8'h17, 8'h3F});
        // Unmapped place and a write with its low lane strobe off
        axw(32'h00000018, 32'h000000FF, 4'hF);
        chk({46'h0, resp}, 48'h2);
        axr(32'h00000018);
        chk({14'h0, resp, rd}, {14'h0, 2'h2, 32'h0});
        axw(32'h00000014, 32'h00000000, 4'hE);
        chk({46'h0, resp}, 48'h0);
        chk({40'h0, e6}, {40'h0, WMASK[47:40]});
        // Every gate combination with all flags raised
        for (int g = 0; g < 8; g++) begin
            drive(48'hFFFFFFFFFFFF, g[2:0]);
            expM = g[2] ? WMASK : (WMASK & ~DISP);
            chk(maskedReq, expM);
            chk({47'h0, periphIrq}, {47'h0, g[1:0] != 2'h0});
        end
        // One source at a time, priority scheme on, display mode off
        for (int k = 0; k < 48; k++) begin
            drive(48'h1 << k, 3'h2);
            chk({47'h0, periphIrq}, {47'h0, WMASK[k] && k != 22});
        end
        // Masking again clears the request
        axw(32'h00000000, 32'h00000000, 4'h1);
        drive(48'h0000000000FF, 3'h1);
        chk({47'h0, periphIrq}, 48'h0);
        // Reset in mid-run with a live request, then bus use right after release
        drive(48'hFFFFFFFFFFFF, 3'h1);
        chk({47'h0, periphIrq}, 48'h1);
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        chk({e6, e5, e4, e3, e2, e1}, 48'h0);
        chk({maskedReq[46:0], periphIrq}, 48'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        axr(32'h0000000C);
        chk({14'h0, resp, rd}, 48'h0);
        chk({47'h0, periphIrq}, 48'h0);
        end_of_test();
    end
endmodule // pieb_enable_bank_tb
